// ### video_tx_strap_config_select.sv
`timescale 1ns/1ns
// Behaviour
// - select high enables serial registers at defaults
// - select low: configuration from strap pins only
// - select low asynchronously resets serial state
// - bus select: high 24-bit, low 12-bit dual
// - serial mode: bus pin clock, clock pin data
// - strap mode: with low swing, clock pin chooses clocking mode
// - edge pin picks rising or falling latch
// - serial mode: edge pin monitors hot plug
// - de-skew shifts capture in fixed trim steps
// - strap de-skew enable uses trim pins
// - serial mode: de-skew from registers, pin tied
// - serial mode: trim pins are address bits
// - strap mode with de-skew: pins are trim
// - power-down register defaults to powered down
module video_tx_strap_config_select
    import video_tx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serial_if_select,
    input wire logic bus_width_select,
    input wire logic clock_mode_select,
    input wire logic hot_plug_detect_in,
    input wire logic skew_trim_enable,
    input wire logic [2:0] skew_trim_code,
    input wire logic power_down_n,
    input wire logic vref_low_swing,
    output logic i2c_sda_out,
    output logic i2c_sda_oe,
    output video_cfg_t video_cfg
);

    strap_pins_t pins_raw;
    strap_pins_t pins_s;
    i2c_slave_t st_r;
    i2c_slave_t st_nxt;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_hit;
    logic [7:0] rd_cur;
    logic [7:0] rd_next;
    logic [7:0] ptr_inc;

    // register read decode, shared by the first and the following read bytes
    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input i2c_cfg_t cfg,
                                            input strap_pins_t pins);
        logic [7:0] val;
        val = 8'h00;
        case (ptr)
            REG_ID: val = DEVICE_ID_VAL;
            REG_CTL: val = cfg.ctl;
            REG_SKEW: val = cfg.skew;
            REG_STATUS: begin
                val[STAT_HPD_BIT] = pins.hot_plug_detect_in;
                val[STAT_SWING_BIT] = pins.vref_low_swing;
            end
            default: val = 8'h00;
        endcase
        reg_read = val;
    endfunction

    // gather the pins so that one synchroniser handles them all
    assign pins_raw = {serial_if_select, bus_width_select, clock_mode_select,
                       hot_plug_detect_in, skew_trim_enable, skew_trim_code,
                       power_down_n, vref_low_swing};

    // pins are used only after two flops, except the raw select that asynchronously clears the slave
    level_sync u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins_s)
    );

    // the bus width and clock mode pins double as serial clock and data
    assign scl = pins_s.bus_width_select;
    assign sda = pins_s.clock_mode_select;

    // bus events from the synchronised levels and their previous copies
    assign scl_rise = scl & ~st_r.scl_q;
    assign scl_fall = ~scl & st_r.scl_q;
    assign start_cond = scl & st_r.scl_q & st_r.sda_q & ~sda;
    assign stop_cond = scl & st_r.scl_q & ~st_r.sda_q & sda;

    // low three address bits come from the multifunction pins
    assign addr_hit = (st_r.shreg[7:1] == {I2C_ADDR_HI, pins_s.skew_trim_code});

    assign ptr_inc = st_r.ptr + 8'h01;
    assign rd_cur = reg_read(st_r.ptr, st_r.cfg, pins_s);
    assign rd_next = reg_read(ptr_inc, st_r.cfg, pins_s);

    // serial slave: address, pointer, then write bytes or read bytes
    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_q = scl;
        st_nxt.sda_q = sda;
        st_nxt.sda_level = 1'b0;
        if (stop_cond) begin
            st_nxt.state = I2C_IDLE;
            st_nxt.sda_oe = 1'b0;
            st_nxt.byte_done = 1'b0;
        end else if (start_cond) begin
            // repeated start is accepted in any state
            st_nxt.state = I2C_ADDR;
            st_nxt.bitcnt = 3'h0;
            st_nxt.byte_done = 1'b0;
            st_nxt.sda_oe = 1'b0;
        end else begin
            case (st_r.state)
                I2C_ADDR, I2C_REG, I2C_WDATA: begin
                    if (scl_rise) begin
                        st_nxt.shreg = {st_r.shreg[6:0], sda};
                        st_nxt.bitcnt = st_r.bitcnt + 3'h1;
                        st_nxt.byte_done = (st_r.bitcnt == 3'h7);
                    end else if (scl_fall && st_r.byte_done) begin
                        st_nxt.byte_done = 1'b0;
                        st_nxt.bitcnt = 3'h0;
                        case (st_r.state)
                            I2C_ADDR: begin
                                if (addr_hit) begin
                                    st_nxt.rw = st_r.shreg[0];
                                    st_nxt.sda_oe = 1'b1;
                                    st_nxt.after_ack = st_r.shreg[0] ? I2C_TX : I2C_REG;
                                    st_nxt.state = I2C_ACK;
                                end else begin
                                    // another slave is addressed; stay off the bus
                                    st_nxt.state = I2C_IDLE;
                                end
                            end
                            I2C_REG: begin
                                st_nxt.ptr = st_r.shreg;
                                st_nxt.sda_oe = 1'b1;
                                st_nxt.after_ack = I2C_WDATA;
                                st_nxt.state = I2C_ACK;
                            end
                            default: begin
                                // writes to read-only or unmapped offsets are acked, dropped
                                if (st_r.ptr == REG_CTL) begin
                                    st_nxt.cfg.ctl = st_r.shreg & CTL_WR_MASK;
                                end
                                if (st_r.ptr == REG_SKEW) begin
                                    st_nxt.cfg.skew = st_r.shreg & SKEW_WR_MASK;
                                end
                                st_nxt.ptr = ptr_inc;
                                st_nxt.sda_oe = 1'b1;
                                st_nxt.after_ack = I2C_WDATA;
                                st_nxt.state = I2C_ACK;
                            end
                        endcase
                    end
                end
                I2C_ACK: begin
                    // acknowledge is held for one full clock low-high-low
                    if (scl_fall) begin
                        st_nxt.state = st_r.after_ack;
                        st_nxt.bitcnt = 3'h0;
                        // only a read address leaves the direction bit set
                        if (st_r.rw) begin
                            st_nxt.shreg = rd_cur;
                            st_nxt.sda_oe = ~rd_cur[7]; // open drain: drive only zeros
                        end else begin
                            st_nxt.sda_oe = 1'b0;
                        end
                    end
                end
                I2C_TX: begin
                    if (scl_fall) begin
                        if (st_r.bitcnt == 3'h7) begin
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.state = I2C_TX_ACK;
                        end else begin
                            st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
                            st_nxt.sda_oe = ~st_r.shreg[6];
                            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
                        end
                    end
                end
                I2C_TX_ACK: begin
                    if (scl_rise && sda) begin
                        // master declined the next byte
                        st_nxt.state = I2C_IDLE;
                    end else if (scl_fall) begin
                        st_nxt.ptr = ptr_inc;
                        st_nxt.shreg = rd_next;
                        st_nxt.sda_oe = ~rd_next[7];
                        st_nxt.bitcnt = 3'h0;
                        st_nxt.state = I2C_TX;
                    end
                end
                default: begin
                    st_nxt.state = I2C_IDLE;
                end
            endcase
        end
    end

    // select low clears the slave without a clock; defaults reload, old contents lost
    always_ff @(posedge mclk or negedge serial_if_select) begin
        if (!serial_if_select) begin
            st_r <= I2C_SLAVE_RESET;
        end else if (sys_rst) begin
            st_r <= I2C_SLAVE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // the output stage ignores the serial registers while the select is low
    cfg_output_stage u_out (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pins(pins_s),
        .regs(st_r.cfg),
        .cfg(video_cfg)
    );

    assign i2c_sda_out = st_r.sda_level;
    assign i2c_sda_oe = st_r.sda_oe;

endmodule

// ### video_tx_cfg_pkg.sv
package video_tx_cfg_pkg;

    // serial slave address: upper four bits fixed, lower three from the trim pins
    localparam logic [3:0] I2C_ADDR_HI = 4'h7; // arbitrary value
    localparam logic [7:0] DEVICE_ID_VAL = 8'h5a; // arbitrary value

    // serial register offsets
    localparam logic [7:0] REG_ID = 8'h00;
    localparam logic [7:0] REG_CTL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h09;
    localparam logic [7:0] REG_SKEW = 8'h0a;

    // control register fields
    localparam int CTL_POWER_BIT = 0;
    localparam int CTL_EDGE_BIT = 1;
    localparam int CTL_WIDTH_BIT = 2;
    localparam int CTL_DIFF_BIT = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WR_MASK = 8'h0f;

    // status register fields
    localparam int STAT_HPD_BIT = 0;
    localparam int STAT_SWING_BIT = 1;

    // skew register fields
    localparam int SKEW_EN_BIT = 0;
    localparam int SKEW_CODE_LSB = 1;
    localparam logic [2:0] SKEW_TRIM_DEFAULT = 3'h4;
    localparam logic [7:0] SKEW_RESET = 8'h08;
    localparam logic [7:0] SKEW_WR_MASK = 8'h0f;

    typedef enum logic [3:0] {
        I2C_IDLE = 4'h0,
        I2C_ADDR = 4'h1,
        I2C_REG = 4'h2,
        I2C_WDATA = 4'h3,
        I2C_ACK = 4'h4,
        I2C_TX = 4'h5,
        I2C_TX_ACK = 4'h6
    } i2c_state_t;

    // strap and multiplexed pins, in the order they are sampled
    typedef struct packed {
        logic serial_if_select;
        logic bus_width_select;
        logic clock_mode_select;
        logic hot_plug_detect_in;
        logic skew_trim_enable;
        logic [2:0] skew_trim_code;
        logic power_down_n;
        logic vref_low_swing;
    } strap_pins_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] skew;
    } i2c_cfg_t;

    // effective configuration handed to the datapath
    typedef struct packed {
        logic i2c_active;
        logic bus_24bit;
        logic dual_edge;
        logic clk_differential;
        logic latch_rising;
        logic power_down_n;
        logic skew_en;
        logic [2:0] skew_code;
        logic [2:0] ctl_code;
        logic hot_plug;
    } video_cfg_t;

    localparam video_cfg_t VIDEO_CFG_RESET = '0;

    typedef struct packed {
        strap_pins_t meta;
        strap_pins_t stable;
    } sync_state_t;

    typedef struct packed {
        i2c_state_t state;
        i2c_state_t after_ack;
        logic [2:0] bitcnt;
        logic byte_done;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic sda_oe;
        logic sda_level;
        logic scl_q;
        logic sda_q;
        i2c_cfg_t cfg;
    } i2c_slave_t;

    localparam i2c_slave_t I2C_SLAVE_RESET = '{
        state: I2C_IDLE,
        after_ack: I2C_IDLE,
        bitcnt: 3'h0,
        byte_done: 1'b0,
        shreg: 8'h00,
        ptr: 8'h00,
        rw: 1'b0,
        sda_oe: 1'b0,
        sda_level: 1'b0,
        scl_q: 1'b1,
        sda_q: 1'b1,
        cfg: '{ctl: CTL_RESET, skew: SKEW_RESET}
    };

endpackage

// ### level_sync.sv
`timescale 1ns/1ns
module level_sync
    import video_tx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire strap_pins_t d,
    output strap_pins_t q
);

    sync_state_t st_r;
    sync_state_t st_nxt;

    // two flops per pin; meta feeds only the stable stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = d;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;

endmodule

// ### cfg_output_stage.sv
`timescale 1ns/1ns
module cfg_output_stage
    import video_tx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire strap_pins_t pins,
    input wire i2c_cfg_t regs,
    output video_cfg_t cfg
);

    video_cfg_t cfg_r;
    video_cfg_t cfg_nxt;

    // differential clocking needs low swing; polarity of the select follows bus width
    function automatic logic clk_mode_decode(input logic width_sel, input logic mode_sel,
                                             input logic low_swing);
        clk_mode_decode = low_swing & (width_sel ? mode_sel : ~mode_sel);
    endfunction

    // choose between serial registers and strap pins
    always_comb begin
        cfg_nxt = VIDEO_CFG_RESET;
        cfg_nxt.i2c_active = pins.serial_if_select;
        if (pins.serial_if_select) begin
            cfg_nxt.bus_24bit = regs.ctl[CTL_WIDTH_BIT];
            cfg_nxt.dual_edge = ~regs.ctl[CTL_WIDTH_BIT];
            cfg_nxt.clk_differential = pins.vref_low_swing & regs.ctl[CTL_DIFF_BIT];
            cfg_nxt.latch_rising = regs.ctl[CTL_EDGE_BIT];
            cfg_nxt.power_down_n = regs.ctl[CTL_POWER_BIT];
            cfg_nxt.skew_en = regs.skew[SKEW_EN_BIT];
            cfg_nxt.skew_code = regs.skew[SKEW_EN_BIT] ?
                regs.skew[SKEW_CODE_LSB +: 3] : SKEW_TRIM_DEFAULT;
            cfg_nxt.hot_plug = pins.hot_plug_detect_in;
        end else begin
            cfg_nxt.bus_24bit = pins.bus_width_select;
            cfg_nxt.dual_edge = ~pins.bus_width_select;
            cfg_nxt.clk_differential = clk_mode_decode(pins.bus_width_select,
                pins.clock_mode_select, pins.vref_low_swing);
            cfg_nxt.latch_rising = pins.hot_plug_detect_in;
            cfg_nxt.power_down_n = pins.power_down_n;
            cfg_nxt.skew_en = pins.skew_trim_enable;
            // trim code is the pins when enabled, otherwise the default step count
            cfg_nxt.skew_code = pins.skew_trim_enable ?
                pins.skew_trim_code : SKEW_TRIM_DEFAULT;
            cfg_nxt.ctl_code = pins.skew_trim_enable ? 3'h0 : pins.skew_trim_code;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r <= VIDEO_CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg = cfg_r;

endmodule

// ### video_tx_cfg_checker_sva.sv
`timescale 1ns/1ns
module video_tx_cfg_checker
    import video_tx_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic serial_if_select,
    input wire logic bus_width_select,
    input wire logic clock_mode_select,
    input wire logic hot_plug_detect_in,
    input wire logic skew_trim_enable,
    input wire logic [2:0] skew_trim_code,
    input wire logic power_down_n,
    input wire logic vref_low_swing,
    input wire logic i2c_sda_out,
    input wire logic i2c_sda_oe,
    input wire video_cfg_t video_cfg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [2:0] strap_r, serial_r, fall_r;
    logic diff_exp;
    logic [2:0] skew_exp;
    // expected strap decodes, compared three cycles later
    assign diff_exp = vref_low_swing & (bus_width_select ~^ clock_mode_select);
    assign skew_exp = skew_trim_enable ? skew_trim_code : SKEW_TRIM_DEFAULT;
    // saturating ages of each mode and of the last serial clock fall
    always_ff @(posedge mclk) begin
        strap_r <= (sys_rst || serial_if_select) ? 3'h0 : strap_r + {2'h0, strap_r != 3'h7};
        serial_r <= (sys_rst || !serial_if_select) ? 3'h0 : serial_r + {2'h0, serial_r != 3'h7};
        fall_r <= $fell(bus_width_select) ? 3'h0 : fall_r + {2'h0, fall_r != 3'h7};
    end
    sequence sel_rise;
        $rose(serial_if_select);
    endsequence
    sequence cfg_default;
        video_cfg.i2c_active && !video_cfg.power_down_n && !video_cfg.skew_en
            && video_cfg.skew_code == SKEW_TRIM_DEFAULT;
    endsequence
    a_strap_width: assert property (
        strap_r > 3'h3 |-> video_cfg.bus_24bit == $past(bus_width_select, 3)
            && video_cfg.dual_edge != $past(bus_width_select, 3))
        else $error("bus width does not follow strap pin");
    a_strap_edge: assert property (
        strap_r > 3'h3 |-> video_cfg.latch_rising == $past(hot_plug_detect_in, 3)
            && !video_cfg.hot_plug && !video_cfg.i2c_active)
        else $error("latch edge does not follow strap pin");
    a_strap_clock: assert property (
        strap_r > 3'h3 |-> video_cfg.clk_differential == $past(diff_exp, 3))
        else $error("clock mode decode wrong");
    a_strap_skew: assert property (
        strap_r > 3'h3 |-> video_cfg.skew_en == $past(skew_trim_enable, 3)
            && video_cfg.skew_code == $past(skew_exp, 3))
        else $error("strap trim wrong");
    a_strap_power: assert property (
        strap_r > 3'h3 |-> video_cfg.power_down_n == $past(power_down_n, 3))
        else $error("strap power down wrong");
    a_serial_hpd: assert property (
        serial_r == 3'h7 |-> video_cfg.i2c_active && video_cfg.ctl_code == 3'h0
            && video_cfg.hot_plug == $past(hot_plug_detect_in, 3))
        else $error("hot plug monitor wrong");
    a_serial_default: assert property (
        sel_rise |-> ##4 cfg_default)
        else $error("registers not at defaults after select");
    a_sel_release: assert property (
        !serial_if_select |-> !i2c_sda_oe)
        else $error("data line held with select low");
    a_open_drain: assert property (
        i2c_sda_out == 1'b0)
        else $error("data line driven high");
    a_ack_timing: assert property (
        serial_r == 3'h7 && $changed(i2c_sda_oe) |-> fall_r inside {[3'h1:3'h4]})
        else $error("data line changed away from clock fall");
endmodule

// ### i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model (
    input wire logic mclk,
    input wire logic dev_oe,
    output logic scl,
    output logic sda
);
    logic pull_r = 1'b0;
    // wire with pull-up: low while either side pulls it
    assign sda = !(pull_r || dev_oe);
    initial scl = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // data moves only in the low phase; sampled mid high phase
    task automatic bit_xfer(input logic b, output logic r);
        scl <= 1'b0;
        tick(2);
        pull_r <= !b;
        tick(5);
        scl <= 1'b1;
        tick(3);
        #1 r = sda;
        tick(3);
    endtask
    // also serves as repeated start, since clock is lowered first
    task automatic start();
        scl <= 1'b0;
        tick(2);
        pull_r <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(5);
        pull_r <= 1'b1;
        tick(5);
    endtask
    task automatic stop();
        scl <= 1'b0;
        tick(2);
        pull_r <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(5);
        pull_r <= 1'b0;
        tick(5);
    endtask
    // msb first, ninth clock carries the acknowledge
    task automatic xfer_byte(input logic [7:0] d, input logic a_in,
                             output logic [7:0] q, output logic a_out);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], q[i]);
        end
        bit_xfer(a_in, a_out);
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module testbench;
    import video_tx_cfg_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic serial_if_select = 1'b0;
    logic width_pin = 1'b0;
    logic mode_pin = 1'b0;
    logic hot_plug_detect_in = 1'b0;
    logic skew_trim_enable = 1'b0;
    logic [2:0] skew_trim_code = 3'h0;
    logic power_down_n = 1'b0;
    logic vref_low_swing = 1'b0;
    logic i2c_sda_out, i2c_sda_oe, scl, sda_w, ack;
    logic bus_width_select, clock_mode_select;
    logic [7:0] rd;
    video_cfg_t video_cfg;
    int num_errors = 0;
    int tests_run = 0;
    localparam logic [7:0] ADDR_W = {I2C_ADDR_HI, 3'h3, 1'b0};
    always #2 mclk = ~mclk;
    // shared pins: host owns them in serial mode, straps otherwise
    assign bus_width_select = serial_if_select ? scl : width_pin;
    assign clock_mode_select = serial_if_select ? sda_w : mode_pin;
    video_tx_strap_config_select u_video_tx_strap_config_select (.mclk, .sys_rst,
        .serial_if_select, .bus_width_select, .clock_mode_select, .hot_plug_detect_in,
        .skew_trim_enable, .skew_trim_code, .power_down_n, .vref_low_swing,
        .i2c_sda_out, .i2c_sda_oe, .video_cfg);
    i2c_host_model host (.mclk(mclk), .dev_oe(i2c_sda_oe), .scl(scl), .sda(sda_w));
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        host.xfer_byte(b, 1'b1, rd, ack);
        `CHK(ack, 1'b0)
    endtask
    task automatic recv(input logic nack, input logic [7:0] e);
        host.xfer_byte(8'hff, nack, rd, ack);
        `CHK(rd, e)
    endtask
    task automatic read_from(input logic [7:0] ptr);
        host.start();
        send(ADDR_W);
        send(ptr);
        host.start();
        send(ADDR_W | 8'h01);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        // strap sweep; each pattern settles past the synchroniser
        for (int i = 0; i < 32; i++) begin
            logic [2:0] c;
            video_cfg_t exp_cfg;
            c = i[2:0] ^ 3'h5;
            {vref_low_swing, skew_trim_enable, hot_plug_detect_in, mode_pin, width_pin} <= i[4:0];
            skew_trim_code <= c;
            power_down_n <= i[1];
            repeat (5) @(posedge mclk);
            exp_cfg = {1'b0, i[0], !i[0], i[4] & (i[0] ~^ i[1]), i[2], i[1], i[3],
                       i[3] ? c : SKEW_TRIM_DEFAULT, i[3] ? 3'h0 : c, 1'b0};
            `CHK(video_cfg, exp_cfg)
        end
        // serial mode: trim pins give address, enable pin tied low
        skew_trim_code <= 3'h3;
        skew_trim_enable <= 1'b0;
        hot_plug_detect_in <= 1'b1;
        vref_low_swing <= 1'b1;
        serial_if_select <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(video_cfg, 14'h2841)
        // burst write runs through the read-only status byte
        host.start();
        send(ADDR_W);
        send(REG_CTL);
        // upper nibbles are written too, so the write masks are exercised
        send(8'hff);
        send(8'hff);
        send(8'hfb);
        host.stop();
        repeat (6) @(posedge mclk);
        `CHK(video_cfg, 14'h37d1)
        read_from(REG_CTL);
        recv(1'b0, 8'h0f);
        recv(1'b0, 8'h03);
        recv(1'b1, 8'h0b);
        host.stop();
        // another address must not be answered
        host.start();
        host.xfer_byte({I2C_ADDR_HI, 3'h4, 1'b0}, 1'b1, rd, ack);
        `CHK(ack, 1'b1)
        host.stop();
        hot_plug_detect_in <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK(video_cfg.hot_plug, 1'b0)
        // select pulse wipes the registers back to defaults
        serial_if_select <= 1'b0;
        repeat (2) @(posedge mclk);
        serial_if_select <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(video_cfg, 14'h2840)
        read_from(REG_CTL);
        recv(1'b0, CTL_RESET);
        recv(1'b0, 8'h02);
        recv(1'b1, SKEW_RESET);
        host.stop();
        // identity byte, then an unmapped offset that reads as zero
        read_from(REG_ID);
        recv(1'b0, DEVICE_ID_VAL);
        recv(1'b1, 8'h00);
        host.stop();
        wrap_up();
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        wrap_up();
    end
endmodule
bind video_tx_strap_config_select video_tx_cfg_checker u_chk (.mclk, .sys_rst,
    .serial_if_select, .bus_width_select, .clock_mode_select, .hot_plug_detect_in,
    .skew_trim_enable, .skew_trim_code, .power_down_n, .vref_low_swing,
    .i2c_sda_out, .i2c_sda_oe, .video_cfg);
